// >>> esb_slave.sv
// Two-wire serial memory bus slave with power-up and programming timers
`timescale 1ns/10ps
module esb_slave
  import esb_pkg::*;
#(
  parameter int POWERUP_CNT = POWERUP_CYCLES,
  parameter int WRITE_CNT = WRITE_CYCLES
) (
  // Clock and reset
  input wire logic clock_in,
  input wire logic reset_in,
  // Supply monitor level, asynchronous
  input wire logic supply_ok_in,
  // Straps and write protect, pulled low outside when undriven
  input wire logic select_bit_0_in,
  input wire logic select_bit_1_in,
  input wire logic select_bit_2_in,
  input wire logic write_protect_in,
  // Bus pins; clock is input only
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe_out,
  // Status
  output logic ready_out,
  output logic busy_out
);
  esb_line_if line ();
  logic [1:0] sup_sync;
  logic [2:0] sel_meta;
  logic [2:0] sel_sync;
  logic wp_meta;
  logic wp_sync;
  logic scl_d;
  logic sda_d;
  logic scl_rise;
  logic scl_fall;
  logic start_ev;
  logic stop_ev;
  logic powered;
  esb_state_t state;
  esb_state_t next_state;
  logic [3:0] bit_cnt;
  logic [3:0] next_bit_cnt;
  logic [7:0] shreg;
  logic [7:0] next_shreg;
  logic rw;
  logic next_rw;
  logic have_word;
  logic next_have_word;
  logic [7:0] ptr;
  logic [7:0] next_ptr;
  logic oe;
  logic next_oe;
  logic [19:0] pu_cnt;
  logic [19:0] next_pu_cnt;
  logic ready;
  logic next_ready;
  logic [19:0] wr_cnt;
  logic [19:0] next_wr_cnt;
  logic busy;
  logic next_busy;
  logic [15:0] pvalid;
  logic [15:0] next_pvalid;
  logic [3:0] page;
  logic [3:0] next_page;
  logic buf_we;
  logic commit;
  logic [7:0] mem [MEM_DEPTH];
  logic [7:0] pbuf [PAGE_DEPTH];

  // Address byte match against preamble and straps
  function automatic logic addr_match(input logic [7:0] b, input logic [2:0] sel);
    addr_match = (b[7:4] == MEM_PREAMBLE) && (b[3:1] == sel);
  endfunction

  esb_glitch_filter u_filter (
    .clock_in(clock_in),
    .reset_in(reset_in),
    .scl_in(scl_in),
    .sda_in(sda_in),
    .line(line.src)
  );

  // Pin level synchronisers for supply, straps and write protect
  always_ff @(posedge clock_in) begin
    if (reset_in) begin
      sup_sync <= 2'h0;
      sel_meta <= 3'h0;
      sel_sync <= 3'h0;
      wp_meta <= 1'b0;
      wp_sync <= 1'b0;
      scl_d <= 1'b1;
      sda_d <= 1'b1;
    end else begin
      sup_sync <= {sup_sync[0], supply_ok_in};
      sel_meta <= {select_bit_2_in, select_bit_1_in, select_bit_0_in};
      sel_sync <= sel_meta;
      wp_meta <= write_protect_in;
      wp_sync <= wp_meta;
      scl_d <= line.scl;
      sda_d <= line.sda;
    end
  end

  // Edge and condition detection on filtered levels
  assign powered = sup_sync[1];
  assign scl_rise = line.scl && !scl_d;
  assign scl_fall = !line.scl && scl_d;
  assign start_ev = line.scl && scl_d && sda_d && !line.sda;
  assign stop_ev = line.scl && scl_d && !sda_d && line.sda;

  // Power-up ready timer and programming timer
  always_comb begin
    next_pu_cnt = pu_cnt;
    next_ready = ready;
    next_busy = busy;
    next_wr_cnt = wr_cnt;
    if (!powered) begin
      next_pu_cnt = 20'h0;
      next_ready = 1'b0;
      next_busy = 1'b0;
      next_wr_cnt = 20'h0;
    end else begin
      if (!ready) begin
        if (pu_cnt == 20'(POWERUP_CNT - 1)) begin
          next_ready = 1'b1;
        end else begin
          next_pu_cnt = pu_cnt + 20'h1;
        end
      end
      if (commit) begin
        next_busy = 1'b1;
        next_wr_cnt = 20'h0;
      end else if (busy) begin
        if (wr_cnt == 20'(WRITE_CNT - 1)) begin
          next_busy = 1'b0;
        end else begin
          next_wr_cnt = wr_cnt + 20'h1;
        end
      end
    end
  end

  always_ff @(posedge clock_in) begin
    if (reset_in) begin
      pu_cnt <= 20'h0;
      ready <= 1'b0;
      busy <= 1'b0;
      wr_cnt <= 20'h0;
    end else begin
      pu_cnt <= next_pu_cnt;
      ready <= next_ready;
      busy <= next_busy;
      wr_cnt <= next_wr_cnt;
    end
  end

  // Protocol engine
  always_comb begin
    next_state = state;
    next_bit_cnt = bit_cnt;
    next_shreg = shreg;
    next_rw = rw;
    next_have_word = have_word;
    next_ptr = ptr;
    next_oe = oe;
    next_pvalid = pvalid;
    next_page = page;
    buf_we = 1'b0;
    commit = 1'b0;
    if (!powered || !ready) begin
      next_state = ESB_IDLE;
      next_oe = 1'b0;
      next_pvalid = 16'h0;
    end else if (start_ev) begin
      next_state = ESB_ADDR;
      next_bit_cnt = 4'h0;
      next_oe = 1'b0;
    end else if (stop_ev) begin
      next_state = ESB_IDLE;
      next_oe = 1'b0;
      next_have_word = 1'b0;
      next_pvalid = 16'h0;
      commit = (pvalid != 16'h0);
    end else begin
      unique case (state)
        ESB_IDLE: begin
          next_oe = 1'b0;
        end
        ESB_ADDR: begin
          if (scl_rise) begin
            next_shreg = {shreg[6:0], line.sda};
            next_bit_cnt = bit_cnt + 4'h1;
          end else if (scl_fall && bit_cnt == LAST_BIT) begin
            if (addr_match(shreg, sel_sync) && !busy) begin
              next_state = ESB_ADDR_ACK;
              next_oe = 1'b1;
              next_rw = shreg[0];
            end else begin
              next_state = ESB_IDLE;
            end
          end
        end
        ESB_ADDR_ACK: begin
          if (scl_fall) begin
            next_bit_cnt = 4'h0;
            if (rw) begin
              next_state = ESB_TX;
              next_shreg = mem[ptr];
              next_oe = !mem[ptr][7];
            end else begin
              next_state = ESB_RX;
              next_oe = 1'b0;
              next_have_word = 1'b0;
            end
          end
        end
        ESB_RX: begin
          if (scl_rise) begin
            next_shreg = {shreg[6:0], line.sda};
            next_bit_cnt = bit_cnt + 4'h1;
          end else if (scl_fall && bit_cnt == LAST_BIT) begin
            next_state = ESB_RX_ACK;
            next_oe = 1'b1;
            if (!have_word) begin
              next_ptr = shreg;
              next_have_word = 1'b1;
            end else if (!wp_sync) begin
              buf_we = 1'b1;
              next_page = ptr[7:4];
              next_pvalid[ptr[3:0]] = 1'b1;
              next_ptr = {ptr[7:4], ptr[3:0] + 4'h1};
            end else begin
              next_ptr = {ptr[7:4], ptr[3:0] + 4'h1};
            end
          end
        end
        ESB_RX_ACK: begin
          if (scl_fall) begin
            next_state = ESB_RX;
            next_oe = 1'b0;
            next_bit_cnt = 4'h0;
          end
        end
        ESB_TX: begin
          if (scl_rise) begin
            next_bit_cnt = bit_cnt + 4'h1;
          end else if (scl_fall) begin
            if (bit_cnt == LAST_BIT) begin
              next_state = ESB_MASTER_ACK;
              next_oe = 1'b0;
              next_ptr = ptr + 8'h1;
            end else begin
              next_shreg = {shreg[6:0], 1'b0};
              next_oe = !shreg[6];
            end
          end
        end
        ESB_MASTER_ACK: begin
          if (scl_rise && line.sda) begin
            next_state = ESB_IDLE;
          end else if (scl_fall) begin
            next_state = ESB_TX;
            next_bit_cnt = 4'h0;
            next_shreg = mem[ptr];
            next_oe = !mem[ptr][7];
          end
        end
        // Unused state code falls back to idle
        default: next_state = ESB_IDLE;
      endcase
    end
  end

  always_ff @(posedge clock_in) begin
    if (reset_in) begin
      state <= ESB_IDLE;
      bit_cnt <= 4'h0;
      shreg <= 8'h0;
      rw <= 1'b0;
      have_word <= 1'b0;
      ptr <= 8'h0;
      oe <= 1'b0;
      pvalid <= 16'h0;
      page <= 4'h0;
    end else begin
      state <= next_state;
      bit_cnt <= next_bit_cnt;
      shreg <= next_shreg;
      rw <= next_rw;
      have_word <= next_have_word;
      ptr <= next_ptr;
      oe <= next_oe;
      pvalid <= next_pvalid;
      page <= next_page;
    end
  end

  // Page buffer load
  always_ff @(posedge clock_in) begin
    if (buf_we) begin
      pbuf[ptr[3:0]] <= shreg;
    end
  end

  // Memory array, delivered erased; committed page written at STOP
  always_ff @(posedge clock_in) begin
    if (reset_in) begin
      for (int i = 0; i < MEM_DEPTH; i++) begin
        mem[i] <= MEM_RESET_VALUE;
      end
    end else if (commit) begin
      for (int j = 0; j < PAGE_DEPTH; j++) begin
        if (pvalid[j]) begin
          mem[{page, 4'(j)}] <= pbuf[j];
        end
      end
    end
  end

  // Open drain data pin; clock pin never driven
  assign sda_out = 1'b0;
  assign sda_oe_out = oe;
  assign ready_out = ready;
  assign busy_out = busy;
endmodule

// >>> esb_pkg.sv
// Constants and types shared by the serial memory bus slave
package esb_pkg;
  localparam int CLK_PERIOD_NS = 8;
  localparam int GLITCH_NS = 100;
  // Stable time needed strictly beyond the glitch width
  localparam int GLITCH_CYCLES = (GLITCH_NS + CLK_PERIOD_NS) / CLK_PERIOD_NS;
  localparam int POWERUP_US = 1000;
  localparam int POWERUP_CYCLES = POWERUP_US * 1000 / CLK_PERIOD_NS;
  localparam int WRITE_US = 5000;
  localparam int WRITE_CYCLES = WRITE_US * 1000 / CLK_PERIOD_NS;
  localparam logic [3:0] MEM_PREAMBLE = 4'ha;
  localparam logic [7:0] MEM_RESET_VALUE = 8'hff;
  localparam logic [3:0] LAST_BIT = 4'h8;
  localparam int MEM_DEPTH = 256;
  localparam int PAGE_DEPTH = 16;
  typedef enum logic [2:0] {
    ESB_IDLE, ESB_ADDR, ESB_ADDR_ACK, ESB_RX, ESB_RX_ACK, ESB_TX, ESB_MASTER_ACK
  } esb_state_t;
endpackage

// >>> esb_line_if.sv
// Filtered bus line levels passed from the input filter to the protocol engine
`timescale 1ns/10ps
interface esb_line_if;
  logic scl;
  logic sda;
  modport src (output scl, output sda);
  modport dst (input scl, input sda);
endinterface

// >>> esb_glitch_filter.sv
// Synchroniser and glitch filter for the serial clock and data inputs
`timescale 1ns/10ps
module esb_glitch_filter
  import esb_pkg::*;
(
  // Clock and reset
  input wire logic clock_in,
  input wire logic reset_in,
  // Raw bus pins
  input wire logic scl_in,
  input wire logic sda_in,
  // Filtered levels
  esb_line_if.src line
);
  logic [1:0] meta;
  logic [1:0] synced;
  logic [1:0] level;
  logic [1:0] next_level;
  logic [3:0] cnt [2];
  logic [3:0] next_cnt [2];

  // Two stage synchroniser, first stage read only by the second
  always_ff @(posedge clock_in) begin
    if (reset_in) begin
      meta <= 2'h3;
      synced <= 2'h3;
    end else begin
      meta <= {sda_in, scl_in};
      synced <= meta;
    end
  end

  // A new level is accepted only after it has held longer than a glitch
  always_comb begin
    for (int i = 0; i < 2; i++) begin
      next_level[i] = level[i];
      next_cnt[i] = 4'h0;
      if (synced[i] != level[i]) begin
        if (cnt[i] == 4'(GLITCH_CYCLES - 1)) begin
          next_level[i] = synced[i];
        end else begin
          next_cnt[i] = cnt[i] + 4'h1;
        end
      end
    end
  end

  always_ff @(posedge clock_in) begin
    if (reset_in) begin
      level <= 2'h3;
      cnt[0] <= 4'h0;
      cnt[1] <= 4'h0;
    end else begin
      level <= next_level;
      cnt[0] <= next_cnt[0];
      cnt[1] <= next_cnt[1];
    end
  end

  assign line.scl = level[0];
  assign line.sda = level[1];
endmodule

// >>> esb_slave_monitor.sv
// Port checks for the serial memory bus slave
`timescale 1ns/10ps
module esb_slave_monitor
  import esb_pkg::*;
#(
  parameter int POWERUP_CNT = POWERUP_CYCLES,
  parameter int WRITE_CNT = WRITE_CYCLES
) (
  // Clock and reset
  input wire logic clock_in,
  input wire logic reset_in,
  // Supply, straps, protect
  input wire logic supply_ok_in,
  input wire logic select_bit_0_in,
  input wire logic select_bit_1_in,
  input wire logic select_bit_2_in,
  input wire logic write_protect_in,
  // Bus pins and status
  input wire logic scl_in,
  input wire logic sda_in,
  input wire logic sda_out,
  input wire logic sda_oe_out,
  input wire logic ready_out,
  input wire logic busy_out
);
  default clocking @(posedge clock_in); endclocking
  default disable iff (reset_in);
  logic [31:0] up_cnt;
  logic [31:0] busy_cnt;
  logic [31:0] next_up_cnt;
  logic [31:0] next_busy_cnt;
  // Good supply cycles out of reset, and length of the busy run
  always_comb begin
    next_up_cnt = (supply_ok_in && !reset_in) ? up_cnt + 32'h1 : 32'h0;
    next_busy_cnt = busy_out ? busy_cnt + 32'h1 : 32'h0;
  end
  always_ff @(posedge clock_in) begin
    up_cnt <= next_up_cnt;
    busy_cnt <= next_busy_cnt;
  end
  open_drain_a: assert property (sda_out == 1'b0) else $error("sda driven high");
  reset_quiet_a: assert property (disable iff (1'b0) reset_in |=>
    !sda_oe_out && !ready_out && !busy_out) else $error("outputs active in reset");
  supply_low_a: assert property ((!supply_ok_in) [*4] |-> !ready_out && !busy_out)
    else $error("active with supply low");
  ready_early_a: assert property ($rose(ready_out) |-> up_cnt >= POWERUP_CNT)
    else $error("ready too early");
  ready_late_a: assert property (up_cnt == POWERUP_CNT + 8 |-> ready_out)
    else $error("ready too late");
  busy_silent_a: assert property (busy_out |-> !sda_oe_out) else $error("ack while busy");
  busy_long_a: assert property (busy_cnt <= WRITE_CNT + 2) else $error("busy too long");
  busy_short_a: assert property ($fell(busy_out) && ready_out |->
    $past(busy_cnt) >= WRITE_CNT - 2) else $error("busy too short");
  stop_start_a: assert property ($rose(busy_out) |-> scl_in && sda_in)
    else $error("busy without stop");
  low_change_a: assert property ($changed(sda_oe_out) |-> !scl_in)
    else $error("sda changed with scl high");
  high_hold_a: assert property ($rose(scl_in) |-> $stable(sda_oe_out) [*8])
    else $error("sda moved after scl rise");
endmodule
bind esb_slave esb_slave_monitor #(.POWERUP_CNT(POWERUP_CNT), .WRITE_CNT(WRITE_CNT)) esb_slave_monitor_inst (
  .clock_in(clock_in), .reset_in(reset_in), .supply_ok_in(supply_ok_in),
  .select_bit_0_in(select_bit_0_in), .select_bit_1_in(select_bit_1_in),
  .select_bit_2_in(select_bit_2_in), .write_protect_in(write_protect_in),
  .scl_in(scl_in), .sda_in(sda_in), .sda_out(sda_out), .sda_oe_out(sda_oe_out),
  .ready_out(ready_out), .busy_out(busy_out));

// >>> esb_master_model.sv
// Two-wire bus master model on the link clock
`timescale 1ns/10ps
module esb_master_model (
  // Link clock and wire level
  input wire logic link_clock_in,
  input wire logic sda_in,
  input wire logic glitch_in,
  // Lines; sda pulled low when set
  output logic scl_out,
  output logic sda_low_out,
  // Observed ack or byte
  output logic [7:0] res_out,
  output logic res_valid_out
);
  // Idle bus: both lines released high
  initial begin
    scl_out = 1'b1;
    sda_low_out = 1'b0;
    res_out = 8'h00;
    res_valid_out = 1'b0;
  end
  task automatic wait_n(input int n);
    repeat (n) @(posedge link_clock_in);
  endtask
  // Bit slot: set mid low, sample mid high; optional short spikes
  task automatic bit_io(input logic b, output logic s);
    wait_n(4);
    sda_low_out <= !b;
    if (glitch_in) begin
      #20 scl_out = 1'b1;
      #64 scl_out = 1'b0;
    end
    wait_n(4);
    scl_out <= 1'b1;
    wait_n(4);
    s = sda_in;
    if (glitch_in) begin
      #20 sda_low_out = 1'b1;
      #64 sda_low_out = !b;
    end
    wait_n(4);
    scl_out <= 1'b0;
  endtask
  task automatic post(input logic [7:0] v);
    res_out <= v;
    res_valid_out <= 1'b1;
    wait_n(1);
    res_valid_out <= 1'b0;
  endtask
  // Start or repeated start, then stop
  task automatic start_cond();
    wait_n(4);
    sda_low_out <= 1'b0;
    wait_n(4);
    scl_out <= 1'b1;
    wait_n(4);
    sda_low_out <= 1'b1;
    wait_n(4);
    scl_out <= 1'b0;
  endtask
  task automatic stop_cond();
    wait_n(4);
    sda_low_out <= 1'b1;
    wait_n(4);
    scl_out <= 1'b1;
    wait_n(4);
    sda_low_out <= 1'b0;
    wait_n(8);
  endtask
  task automatic put_byte(input logic [7:0] d);
    logic s;
    for (int i = 7; i >= 0; i--) bit_io(d[i], s);
    bit_io(1'b1, s);
    post({7'h00, s});
  endtask
  task automatic get_byte(input logic nack);
    logic [7:0] d;
    logic s;
    for (int i = 7; i >= 0; i--) begin
      bit_io(1'b1, s);
      d[i] = s;
    end
    bit_io(nack, s);
    post(d);
  endtask
endmodule

// >>> serial_eeprom_bus_slave_interface_test.sv
// Self-checking bench for the serial memory bus slave
`timescale 1ns/10ps
module serial_eeprom_bus_slave_interface_test;
  import esb_pkg::*;
  localparam int WR = 5000;
  logic clock_in = 1'b0;
  logic link_clock = 1'b0;
  logic reset_in = 1'b1;
  logic supply_ok = 1'b1;
  logic [2:0] sel = 3'h0;
  logic wp = 1'b0;
  logic glitch = 1'b0;
  logic scl, sda_low, sda_drv, sda_oe, sda_w, ready, busy, res_valid;
  logic [7:0] res, ptr, data;
  logic [31:0] rng;
  logic [7:0] expq[$];
  int mismatches = 0;
  int comparisons = 0;
  always #4 clock_in = ~clock_in;
  always #62.5 link_clock = ~link_clock;
  // Open-drain wire with pull-up
  assign sda_w = !sda_low && !(sda_oe && !sda_drv);
  esb_slave #(.POWERUP_CNT(50), .WRITE_CNT(WR)) esb_slave_inst (
    .clock_in(clock_in), .reset_in(reset_in), .supply_ok_in(supply_ok),
    .select_bit_0_in(sel[0]), .select_bit_1_in(sel[1]), .select_bit_2_in(sel[2]),
    .write_protect_in(wp), .scl_in(scl), .sda_in(sda_w), .sda_out(sda_drv),
    .sda_oe_out(sda_oe), .ready_out(ready), .busy_out(busy));
  esb_master_model esb_master_model_inst (.link_clock_in(link_clock), .sda_in(sda_w),
    .glitch_in(glitch), .scl_out(scl), .sda_low_out(sda_low), .res_out(res), .res_valid_out(res_valid));
  task automatic fail(input string m);
    mismatches++;
    $display("[FAIL] %0t %s", $time, m);
  endtask
  task automatic test_done();
    if (mismatches == 0 && comparisons > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  function automatic logic [31:0] xs(input logic [31:0] x);
    x ^= x << 13;
    x ^= x >> 17;
    x ^= x << 5;
    return x;
  endfunction
  // Bounded wait for a status level
  task automatic wait_for(ref logic s, input logic v, input int n);
    for (int i = 0; i < n && s !== v; i++) @(posedge clock_in);
    comparisons++;
    if (s !== v) begin
      fail("status wait ran out");
      test_done();
    end
  endtask
  task automatic send(input logic [7:0] d, input logic [7:0] e);
    expq.push_back(e);
    esb_master_model_inst.put_byte(d);
  endtask
  task automatic rd(input logic nack, input logic [7:0] e);
    expq.push_back(e);
    esb_master_model_inst.get_byte(nack);
  endtask
  task automatic st();
    esb_master_model_inst.start_cond();
  endtask
  task automatic sp();
    esb_master_model_inst.stop_cond();
  endtask
  // Dummy write, repeated start, read two bytes
  task automatic sel_read(input logic [7:0] e);
    st();
    send({4'ha, sel, 1'b0}, 8'h00);
    send(ptr, 8'h00);
    st();
    send({4'ha, sel, 1'b1}, 8'h00);
    rd(1'b0, e);
    rd(1'b1, MEM_RESET_VALUE);
    sp();
  endtask
  // Compare each observed result with the oldest note
  always @(posedge link_clock) begin
    if (res_valid) begin
      comparisons++;
      if (expq.size() == 0 || res !== expq[0]) fail("bus result differs");
      if (expq.size() != 0) void'(expq.pop_front());
    end
  end
  initial begin
    rng = 32'h61dc;
    repeat (16) @(posedge clock_in);
    rng = xs(rng);
    reset_in <= 1'b0;
    sel <= rng[2:0];
    ptr = rng[15:8];
    data = rng[23:16];
    wait_for(ready, 1'b1, 400);
    st();
    send({4'ha, sel, 1'b0}, 8'h00);
    send(ptr, 8'h00);
    send(data, 8'h00);
    sp();
    wait_for(busy, 1'b1, 4);
    st();
    send({4'ha, sel, 1'b0}, 8'h01);
    sp();
    wait_for(busy, 1'b0, WR);
    st();
    send({4'ha, ~sel, 1'b0}, 8'h01);
    st();
    send({4'h6, sel, 1'b1}, 8'h01);
    sp();
    @(posedge clock_in);
    glitch <= 1'b1;
    sel_read(data);
    @(posedge clock_in);
    glitch <= 1'b0;
    wp <= 1'b1;
    st();
    send({4'ha, sel, 1'b0}, 8'h00);
    send(ptr, 8'h00);
    send(~data, 8'h00);
    sp();
    wait_for(busy, 1'b0, 1);
    sel_read(data);
    @(posedge clock_in);
    wp <= 1'b0;
    supply_ok <= 1'b0;
    repeat (10) @(posedge clock_in);
    wait_for(ready, 1'b0, 1);
    supply_ok <= 1'b1;
    wait_for(ready, 1'b1, 400);
    st();
    send({4'ha, sel, 1'b0}, 8'h00);
    sp();
    comparisons++;
    if (expq.size() != 0) fail("results missing");
    test_done();
  end
endmodule
